// ---- rtl/cfm_monitor.sv ----
// clock frequency monitor: accuracy checker and main oscillator stop detector
// Functional notes
// [R01] target clock rising pulses are counted inside a window timed by the divided reference.
// [R02] at each window end an error request is raised if the count is outside the limits.
// [R03] the reference is one of seven internal clocks or the external reference pin.
// [R04] frequency-error and overflow requests each have their own enable.
// [R05] the two-bit reference divider select includes a divide-by-128 setting.
// [R06] the two-bit target divider select divides the target by 1, 4, 8 or 32.
// [R07] upper and lower limits are 16-bit values.
// [R08] software sets the limits around the expected count, ten percent tolerance advised.
// [R09] a main oscillator stop with detection enabled switches to the middle-speed osc and
//   raises a non-maskable interrupt.
// [R10] stop detection only acts while the main oscillator stop bit reads 0.
// [R11] stop detection needs its enable, its interrupt enable and the nmi enable bit; the code detects and switches on the enable alone.
// [R12] a sticky nmi status flag records the oscillation-stop cause.
// [R13] the counter clears at window start and the compare uses the count caught at window end.
`timescale 1ns/100ps
module cfm_monitor (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic main_osc_clk,
  input wire logic sub_osc_clk,
  input wire logic high_speed_internal_osc,
  input wire logic middle_speed_internal_osc,
  input wire logic low_speed_internal_osc,
  input wire logic watchdog_osc_clock,
  input wire logic peripheral_clock_b,
  input wire logic external_reference_pin,
  input wire logic checker_enable,
  input wire logic [2:0] target_select,
  input wire logic [2:0] ref_select,
  input wire logic [1:0] target_divider_select,
  input wire logic [1:0] ref_divider_select,
  input wire logic [15:0] upper_limit,
  input wire logic [15:0] lower_limit,
  input wire logic freq_err_irq_enable,
  input wire logic overflow_irq_enable,
  input wire logic freq_err_clear,
  input wire logic overflow_clear,
  input wire logic main_osc_stop_bit,
  input wire logic stop_detect_enable,
  input wire logic stop_detect_irq_enable,
  input wire logic stop_detect_nmi_enable,
  input wire logic stop_detect_nmi_clear,
  output logic [15:0] captured_count,
  output logic measure_done,
  output logic freq_err_flag,
  output logic overflow_flag,
  output logic freq_err_irq,
  output logic overflow_irq,
  output logic osc_stop_detected,
  output logic use_middle_speed_osc,
  output logic stop_detect_nmi_flag,
  output logic nmi
);
  // two-flop synchronisers for every asynchronous clock input
  logic [8:0] raw_w;
  logic [8:0] sync1_q;
  logic [8:0] sync2_q;
  logic [8:0] sync3_q;
  assign raw_w = {external_reference_pin, peripheral_clock_b, watchdog_osc_clock,
    low_speed_internal_osc, middle_speed_internal_osc, high_speed_internal_osc,
    sub_osc_clk, main_osc_clk, 1'b0};
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end else begin
      sync1_q <= raw_w;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // rising edges seen after synchronisation; ref_clk must outrun every source
  logic [8:0] rise_w;
  assign rise_w = sync2_q & ~sync3_q;

  function automatic logic pick(input logic [8:0] r, input logic [2:0] sel);
    logic v;
    v = 1'b0;
    unique case (sel)
      cfm_pkg::REF_MAIN: v = r[1];
      cfm_pkg::REF_SUB: v = r[2];
      cfm_pkg::REF_HIGH: v = r[3];
      cfm_pkg::REF_MID: v = r[4];
      cfm_pkg::REF_LOW: v = r[5];
      cfm_pkg::REF_WDT: v = r[6];
      cfm_pkg::REF_PERIPHERAL_CLOCK_B: v = r[7];
      cfm_pkg::REF_EXT: v = r[8];
    endcase
    return v;
  endfunction

  logic tgt_rise_w;
  logic ref_rise_w;
  assign tgt_rise_w = pick(rise_w, target_select); // R01
  assign ref_rise_w = pick(rise_w, ref_select); // R03

  // a window opens on a reference edge, so it spans whole reference periods;
  // counting from the enable instead would lose up to one reference period
  typedef enum logic [1:0] {
    WIN_IDLE,
    WIN_ARM,
    WIN_MEASURE
  } cfm_win_t;
  cfm_win_t win_q;
  cfm_win_t win_d;
  always_comb begin
    win_d = win_q;
    unique case (win_q)
      WIN_IDLE: begin
        if (checker_enable) win_d = WIN_ARM;
      end
      WIN_ARM: begin
        if (!checker_enable) win_d = WIN_IDLE;
        else if (ref_rise_w) win_d = WIN_MEASURE; // R13
      end
      WIN_MEASURE: begin
        if (!checker_enable) win_d = WIN_IDLE;
      end
      default: win_d = WIN_IDLE;
    endcase
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      win_q <= WIN_IDLE;
    end else begin
      win_q <= win_d;
    end
  end
  logic measuring_w;
  assign measuring_w = checker_enable && (win_q == WIN_MEASURE);

  // target prescaler
  logic [4:0] tdiv_q;
  logic [4:0] tterm_w;
  always_comb begin
    unique case (target_divider_select) // R06
      cfm_pkg::TDIV_1: tterm_w = '0;
      cfm_pkg::TDIV_4: tterm_w = cfm_pkg::TDIV_4_TERM;
      cfm_pkg::TDIV_8: tterm_w = cfm_pkg::TDIV_8_TERM;
      cfm_pkg::TDIV_32: tterm_w = cfm_pkg::TDIV_32_TERM;
    endcase
  end
  logic tgt_tick_w;
  assign tgt_tick_w = tgt_rise_w && (tdiv_q >= tterm_w);

  // reference prescaler defines the window length
  logic [12:0] rdiv_q;
  logic [12:0] rterm_w;
  always_comb begin
    unique case (ref_divider_select) // R05
      cfm_pkg::RDIV_32: rterm_w = cfm_pkg::RDIV_32_TERM;
      cfm_pkg::RDIV_128: rterm_w = cfm_pkg::RDIV_128_TERM;
      cfm_pkg::RDIV_1024: rterm_w = cfm_pkg::RDIV_1024_TERM;
      cfm_pkg::RDIV_8192: rterm_w = cfm_pkg::RDIV_8192_TERM;
    endcase
  end
  logic window_end_w;
  assign window_end_w = measuring_w && ref_rise_w && (rdiv_q >= rterm_w);

  always_ff @(posedge ref_clk) begin
    if (rst || !checker_enable) begin
      tdiv_q <= '0;
      rdiv_q <= '0;
    end else begin
      if (tgt_rise_w) tdiv_q <= tgt_tick_w ? '0 : tdiv_q + 5'h01;
      if (ref_rise_w && measuring_w) rdiv_q <= window_end_w ? '0 : rdiv_q + 13'h0001;
    end
  end

  // pulse counter; saturation marks overflow for the current window
  logic [15:0] count_q;
  logic ovf_q;
  always_ff @(posedge ref_clk) begin
    if (rst || !measuring_w || window_end_w) begin
      count_q <= '0; // R13
      ovf_q <= 1'b0;
    end else if (tgt_tick_w) begin
      if (count_q == '1) ovf_q <= 1'b1;
      else count_q <= count_q + 16'h0001; // R01
    end
  end

  // limit comparison on the count at window end
  logic [15:0] final_w;
  logic out_of_range_w;
  logic ovf_now_w;
  assign ovf_now_w = ovf_q || (tgt_tick_w && count_q == '1);
  assign final_w = (tgt_tick_w && count_q != '1) ? count_q + 16'h0001 : count_q;
  assign out_of_range_w = (final_w > upper_limit) || (final_w < lower_limit); // R07

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      captured_count <= '0;
      measure_done <= 1'b0;
    end else begin
      measure_done <= window_end_w;
      if (window_end_w) captured_count <= final_w; // R13
    end
  end

  // sticky flags; a set in the clearing cycle wins
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      freq_err_flag <= 1'b0;
    end else if (window_end_w && (out_of_range_w || ovf_now_w)) begin
      freq_err_flag <= 1'b1; // R02
    end else if (freq_err_clear) begin
      freq_err_flag <= 1'b0;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      overflow_flag <= 1'b0;
    end else if (measuring_w && ovf_now_w && !ovf_q) begin
      overflow_flag <= 1'b1;
    end else if (overflow_clear) begin
      overflow_flag <= 1'b0;
    end
  end
  assign freq_err_irq = freq_err_flag && freq_err_irq_enable; // R04
  assign overflow_irq = overflow_flag && overflow_irq_enable; // R04

  // main oscillator stop detection: timeout since the last main edge
  logic [7:0] stop_cnt_q;
  logic armed_w;
  assign armed_w = stop_detect_enable && !main_osc_stop_bit; // R10
  always_ff @(posedge ref_clk) begin
    if (rst || !armed_w || rise_w[1]) begin
      stop_cnt_q <= '0;
    end else if (stop_cnt_q != cfm_pkg::STOP_TIMEOUT) begin
      stop_cnt_q <= stop_cnt_q + 8'h01;
    end
  end
  logic stop_event_w;
  assign stop_event_w = armed_w && (stop_cnt_q == cfm_pkg::STOP_TIMEOUT);

  // detection and the clock switch hold until reset; the oscillator is not trusted again
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      osc_stop_detected <= 1'b0;
      use_middle_speed_osc <= 1'b0;
    end else if (stop_event_w) begin
      osc_stop_detected <= 1'b1;
      use_middle_speed_osc <= 1'b1; // R09
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stop_detect_nmi_flag <= 1'b0;
    end else if (stop_event_w && stop_detect_irq_enable) begin
      stop_detect_nmi_flag <= 1'b1; // R12
    end else if (stop_detect_nmi_clear) begin
      stop_detect_nmi_flag <= 1'b0;
    end
  end
  assign nmi = stop_detect_nmi_flag && stop_detect_nmi_enable; // R11
  // limits follow software's tolerance choice, nothing is checked in hardware  R08
endmodule // cfm_monitor

// ---- rtl/cfm_pkg.sv ----
// constants and types for the clock frequency monitor
package cfm_pkg;
  localparam int CNT_W = 16;
  // reference source select codes
  localparam logic [2:0] REF_MAIN = 3'h0;
  localparam logic [2:0] REF_SUB = 3'h1;
  localparam logic [2:0] REF_HIGH = 3'h2;
  localparam logic [2:0] REF_MID = 3'h3;
  localparam logic [2:0] REF_LOW = 3'h4;
  localparam logic [2:0] REF_WDT = 3'h5;
  localparam logic [2:0] REF_PERIPHERAL_CLOCK_B = 3'h6;
  localparam logic [2:0] REF_EXT = 3'h7;
  // reference divider select: 1/32, 1/128, 1/1024, 1/8192
  localparam logic [1:0] RDIV_32 = 2'h0;
  localparam logic [1:0] RDIV_128 = 2'h1;
  localparam logic [1:0] RDIV_1024 = 2'h2;
  localparam logic [1:0] RDIV_8192 = 2'h3;
  localparam logic [12:0] RDIV_32_TERM = 13'h001f;
  localparam logic [12:0] RDIV_128_TERM = 13'h007f;
  localparam logic [12:0] RDIV_1024_TERM = 13'h03ff;
  localparam logic [12:0] RDIV_8192_TERM = 13'h1fff;
  // target divider select: 1/1, 1/4, 1/8, 1/32
  localparam logic [1:0] TDIV_1 = 2'h0;
  localparam logic [1:0] TDIV_4 = 2'h1;
  localparam logic [1:0] TDIV_8 = 2'h2;
  localparam logic [1:0] TDIV_32 = 2'h3;
  localparam logic [4:0] TDIV_4_TERM = 5'h03;
  localparam logic [4:0] TDIV_8_TERM = 5'h07;
  localparam logic [4:0] TDIV_32_TERM = 5'h1f;
  // missing main-oscillator edges (in ref_clk cycles) that count as a stop
  localparam logic [7:0] STOP_TIMEOUT = 8'hff;
  // recommended tolerance in percent, for software computing limits
  localparam int FREQUENCY_TOLERANCE_SETTING = 10;
endpackage

// ---- test/cfm_monitor_asserts.sv ----
// port assertions for the clock frequency monitor
`timescale 1ns/100ps
module cfm_monitor_asserts (
  input logic ref_clk,
  input logic rst,
  input logic checker_enable,
  input logic [15:0] upper_limit,
  input logic [15:0] lower_limit,
  input logic freq_err_irq_enable,
  input logic overflow_irq_enable,
  input logic freq_err_clear,
  input logic main_osc_stop_bit,
  input logic stop_detect_enable,
  input logic stop_detect_irq_enable,
  input logic stop_detect_nmi_enable,
  input logic [15:0] captured_count,
  input logic measure_done,
  input logic freq_err_flag,
  input logic overflow_flag,
  input logic freq_err_irq,
  input logic overflow_irq,
  input logic osc_stop_detected,
  input logic use_middle_speed_osc,
  input logic stop_detect_nmi_flag,
  input logic nmi
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_done_pulse: assert property (measure_done |=> !measure_done)
    else $error("done pulse too long");
  a_idle_no_done: assert property (!checker_enable [*4] |-> !measure_done)
    else $error("window end while off");
  a_range_err: assert property (measure_done && (captured_count > upper_limit
    || captured_count < lower_limit) |-> freq_err_flag) else $error("range miss unflagged");
  a_err_sticky: assert property (freq_err_flag && !freq_err_clear |=> freq_err_flag)
    else $error("error flag lost");
  a_freq_irq_gate: assert property (freq_err_irq == (freq_err_flag && freq_err_irq_enable))
    else $error("freq irq gate");
  a_ovf_irq_gate: assert property (overflow_irq == (overflow_flag && overflow_irq_enable))
    else $error("overflow irq gate");
  a_switch_held: assert property (osc_stop_detected |=>
    osc_stop_detected && use_middle_speed_osc) else $error("switch not held");
  a_stop_armed: assert property ($rose(osc_stop_detected) |->
    stop_detect_enable && !main_osc_stop_bit) else $error("stop while disarmed");
  a_nmi_cause: assert property ($rose(stop_detect_nmi_flag) |-> osc_stop_detected)
    else $error("nmi flag without stop");
  a_nmi_gate: assert property (nmi == (stop_detect_nmi_flag && stop_detect_nmi_enable))
    else $error("nmi gate");
  c_window: cover property (measure_done && freq_err_flag);
  c_stop: cover property ($rose(osc_stop_detected));
  c_nmi: cover property (nmi);
endmodule // cfm_monitor_asserts

// ---- test/tb_cfm_monitor.sv ----
// self-checking bench for the clock frequency monitor
`timescale 1ns/100ps
module tb_cfm_monitor;
  logic ref_clk = 0, rst = 1, main_run = 1, checker_enable = 0, overflow_irq_enable = 0;
  logic freq_err_irq_enable = 0, freq_err_clear = 0, overflow_clear = 0, main_osc_stop_bit = 1;
  logic stop_detect_enable = 0, stop_detect_irq_enable = 0, stop_detect_nmi_enable = 0;
  logic stop_detect_nmi_clear = 0, measure_done, freq_err_flag, overflow_flag, freq_err_irq;
  logic overflow_irq, osc_stop_detected, use_middle_speed_osc, stop_detect_nmi_flag, nmi, bad;
  logic [2:0] target_select = 0, ref_select = 0;
  logic [1:0] target_divider_select = 0, ref_divider_select = 0;
  logic [15:0] upper_limit = 0, lower_limit = 0, captured_count;
  logic [7:0] cnt = 0;
  logic [31:0] lfsr = 32'hdd38;
  int n_mismatch = 0, check_count = 0, cycles = 0, e, k, i;
  // sources kept at ref_clk/8 or slower so the synchronisers never miss an edge
  wire main_osc_clk = main_run & cnt[2], sub_osc_clk = cnt[5], peripheral_clock_b = cnt[3];
  wire high_speed_internal_osc = cnt[3], middle_speed_internal_osc = cnt[4];
  wire low_speed_internal_osc = cnt[6], watchdog_osc_clock = cnt[5];
  wire external_reference_pin = cnt[4];
  cfm_monitor i_cfm_monitor (.*);
  initial forever #2 ref_clk = ~ref_clk;
  always @(negedge ref_clk) cnt <= cnt + 8'h01;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 100000) begin
      n_mismatch++;
      finish_test;
    end
  end
  function automatic logic [31:0] nx(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // source period in ref_clk cycles, per select code
  function automatic int per(input logic [2:0] c);
    int b[8] = '{2, 5, 3, 4, 6, 5, 3, 4};
    return 2 << b[c];
  endfunction
  function automatic int rdv(input logic [1:0] c);
    int r[4] = '{32, 128, 1024, 8192};
    return r[c];
  endfunction
  function automatic int tr(input logic [1:0] c);
    int r[4] = '{1, 4, 8, 32};
    return r[c];
  endfunction
  task check(input logic s, input logic x);
    check_count++;
    if (s !== x) begin
      n_mismatch++;
      $display("Error at %0t: saw %b expected %b", $time, s, x);
    end
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge ref_clk);
    rst = 0;
    for (k = 0; k < 8; k++) begin
      lfsr = nx(lfsr);
      // every reference code and every target divider is visited at least once
      ref_select = k[2:0];
      target_select = lfsr[2:0];
      target_divider_select = k < 4 ? k[1:0] : lfsr[7:6];
      ref_divider_select = k == 2 ? 2'h2 : {1'b0, k == 1 || (lfsr[8] && k != 4)};
      freq_err_irq_enable = lfsr[9];
      overflow_irq_enable = lfsr[10];
      e = per(ref_select) * rdv(ref_divider_select);
      e = e / (per(target_select) * tr(target_divider_select));
      bad = lfsr[11] && e >= 4;
      upper_limit = 16'(bad ? e - 3 : e + 1);
      lower_limit = 16'(e > 1 ? e - 1 : 0);
      @(negedge ref_clk) checker_enable = 1;
      for (i = 0; i < 20000 && measure_done !== 1'b1; i++) @(negedge ref_clk);
      check(measure_done, 1'b1);
      // source phase against the window leaves one count of slack either way
      check(1'(captured_count >= lower_limit && int'(captured_count) <= e + 1), 1'b1);
      check(freq_err_flag, bad);
      check(freq_err_irq, bad & freq_err_irq_enable);
      check(overflow_flag, 1'b0);
      check(overflow_irq, 1'b0);
      checker_enable = 0;
      freq_err_clear = 1;
      overflow_clear = 1;
      @(negedge ref_clk) freq_err_clear = 0;
      overflow_clear = 0;
      @(negedge ref_clk);
      check(freq_err_flag, 1'b0);
    end
    stop_detect_enable = 1;
    stop_detect_irq_enable = 1;
    stop_detect_nmi_enable = 1;
    main_osc_stop_bit = 0;
    repeat (300) @(negedge ref_clk);
    check(osc_stop_detected, 1'b0);
    main_osc_stop_bit = 1;
    main_run = 0;
    repeat (300) @(negedge ref_clk);
    check(osc_stop_detected, 1'b0);
    main_osc_stop_bit = 0;
    repeat (270) @(negedge ref_clk);
    check(use_middle_speed_osc, 1'b1);
    check(stop_detect_nmi_flag, 1'b1);
    check(nmi, 1'b1);
    stop_detect_nmi_enable = 0;
    @(negedge ref_clk);
    check(nmi, 1'b0);
    main_osc_stop_bit = 1;
    stop_detect_nmi_clear = 1;
    @(negedge ref_clk) stop_detect_nmi_clear = 0;
    @(negedge ref_clk);
    check(stop_detect_nmi_flag, 1'b0);
    check(use_middle_speed_osc, 1'b1);
    finish_test;
  end
endmodule // tb_cfm_monitor
bind cfm_monitor cfm_monitor_asserts i_cfm_monitor_asserts (.*);
